// ==== rtl/switch_mode_ctrl.sv ====
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
// ---------------------------------------------------------
// operating-mode controller, two channels
// ---------------------------------------------------------
module switch_mode_ctrl
	import hs_ctrl_pkg::*;
#(
	parameter int unsigned IN_TIMEOUT = IN_TIMEOUT_CYC, // input idle limit
	parameter int unsigned WD_TIMEOUT = WD_TIMEOUT_CYC, // watchdog limit
	parameter int unsigned READY_CYCLES = READY_CYC // wake to ready
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// device pins and sense
	input wire logic reset_wake_i,
	input wire logic [1:0] in_i,
	input wire logic pwm_clk_i,
	input wire logic vdd_lost_i,
	input wire fault_in_t faults_i,
	input wire logic failsafe_flag_i,
	output logic failsafe_flag_o,
	output logic failsafe_flag_oe_o,
	// channel control
	output logic [1:0] hson_o,
	output drive_cfg_t [1:0] drive_cfg_o,
	output op_mode_t mode_o,
	output logic normal_state_flag_o,
	output logic ready_o
);

	// ---------------------------------------------------------
	// state
	// ---------------------------------------------------------
	localparam int RW = $clog2(READY_CYCLES + 1);
	localparam logic [RW-1:0] READY_LAST = RW'(READY_CYCLES);

	typedef struct packed {
		regs_t regs; // software registers
		op_mode_t mode; // registered mode
		logic fs_latch; // fail-safe condition caught
		logic exit_armed; // toggle-one word seen in fail-safe
		logic wd_on; // watchdog started by pin edge
		logic wd_last; // last toggle bit written
		logic pin_last; // reset_wake_pin last cycle
		logic ext_last; // external clock last cycle
		logic ready; // functions available
		logic [RW-1:0] ready_cnt; // cycles since wake
		logic [1:0][7:0] pwm_cnt; // pulse period counters
		logic [1:0][DIV_W-1:0] pre_cnt; // internal prescalers
		logic [1:0] hson; // channel on-commands
		drive_cfg_t [1:0] cfg; // delay and slew per channel
		logic [31:0] prdata; // read data
	} ctl_state_t;

	localparam ctl_state_t ST_RST = '{regs: REGS_RST, mode: MODE_SLEEP, default: '0};

	ctl_state_t st; // registered state
	ctl_state_t nxt; // next state

	logic [1:0] in_on; // input activity flags
	logic wd_alive; // watchdog not expired
	logic wd_run; // watchdog counting
	logic wd_restart; // watchdog restart event
	logic wake; // wake-up term
	logic fault_term; // fault term
	logic fs_term; // fail-safe term
	op_mode_t mode_now; // mode decoded this cycle
	logic direct; // inputs alone drive channels
	logic apb_access; // access phase
	logic apb_wr; // write taken this cycle
	logic wr_ok; // registers may change
	logic tog; // toggle bit of the write
	logic pin_rise; // rising pin edge
	logic [3:0] sel; // register selected by address

	// ---------------------------------------------------------
	// helpers
	// ---------------------------------------------------------
	// address to register index, 15 for unmapped
	function automatic logic [3:0] reg_sel(input logic [7:0] a);
		logic [3:0] r;
		r = 4'hF;
		case (a)
			OFS_GCR: r = 4'h0;
			OFS_PW0: r = 4'h1;
			OFS_PW1: r = 4'h2;
			OFS_SETUP0: r = 4'h3;
			OFS_SETUP1: r = 4'h4;
			OFS_LIMIT0: r = 4'h5;
			OFS_LIMIT1: r = 4'h6;
			OFS_STATUS: r = 4'h7;
			default: r = 4'hF;
		endcase
		return r;
	endfunction

	// zero-extend a stored register to the bus width
	function automatic logic [31:0] word(input logic [REG_W-1:0] v);
		return {{(32 - REG_W){1'b0}}, v};
	endfunction

	// ---------------------------------------------------------
	// timers
	// ---------------------------------------------------------
	// per-channel activity, restarted while the input is high
	for (genvar c = 0; c < 2; c++) begin : g_act
		activity_timer #(
			.LIMIT(IN_TIMEOUT),
			.START_ALIVE(1'b0)
		) u_act (
			.clk_i(clk_i),
			.srst_i(srst_i),
			.ce_i(ce_i),
			.restart_i(in_i[c]),
			.run_i(1'b1),
			.alive_o(in_on[c])
		);
	end

	// serial watchdog, also times the fail-safe exit window
	activity_timer #(
		.LIMIT(WD_TIMEOUT),
		.START_ALIVE(1'b1)
	) u_wd (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.ce_i(ce_i),
		.restart_i(wd_restart),
		.run_i(wd_run),
		.alive_o(wd_alive)
	);

	// ---------------------------------------------------------
	// mode terms
	// ---------------------------------------------------------
	always_comb begin
		wake = reset_wake_i | in_on[0] | in_on[1];
		fault_term = (|faults_i.oc) | (|faults_i.ot) | (|faults_i.sc) | faults_i.uv
			| (faults_i.ov & st.regs.global_control_reg[GCR_OV_GATE]);
		fs_term = st.fs_latch;
		// fault beats fail-safe, sleep beats both
		if (!wake) begin
			mode_now = MODE_SLEEP;
		end else if (fault_term) begin
			mode_now = MODE_FAULT;
		end else if (fs_term) begin
			mode_now = MODE_FAILSAFE;
		end else begin
			mode_now = MODE_NORMAL;
		end
		direct = !reset_wake_i || fs_term;
	end

	// ---------------------------------------------------------
	// bus and watchdog control
	// ---------------------------------------------------------
	always_comb begin
		apb_access = psel_i && penable_i && ce_i;
		sel = reg_sel(paddr_i);
		apb_wr = apb_access && pwrite_i;
		// registers stay at default while the pin is low
		wr_ok = st.ready && !fs_term && reset_wake_i;
		tog = pwdata_i[TOGGLE_BIT];
		pin_rise = reset_wake_i && !st.pin_last;
		// pin edge starts it, a flipped toggle bit feeds it
		wd_restart = pin_rise || st.regs.global_control_reg[GCR_WD_OFF] || (apb_wr && (tog != st.wd_last)) ||
			(apb_wr && fs_term && tog && !st.exit_armed);
		wd_run = (st.wd_on && mode_now == MODE_NORMAL && !vdd_lost_i &&
			!st.regs.global_control_reg[GCR_WD_OFF] && reset_wake_i) ||
			(fs_term && st.exit_armed);
	end

	// zero wait states; errors for unmapped or refused writes
	assign pready_o = apb_access;
	assign pslverr_o = apb_access && (sel == 4'hF || (pwrite_i && (sel == 4'h7 || !wr_ok)));

	// ---------------------------------------------------------
	// next state
	// ---------------------------------------------------------
	always_comb begin
		logic duty_sig;
		logic cmd;
		logic tick;
		logic on_bit;
		logic dctl;
		logic [REG_W-1:0] pw;
		logic [REG_W-1:0] su;
		duty_sig = 1'b0;
		cmd = 1'b0;
		tick = 1'b0;
		on_bit = 1'b0;
		dctl = 1'b0;
		pw = '0;
		su = '0;
		nxt = st;
		nxt.mode = mode_now;
		nxt.pin_last = reset_wake_i;
		nxt.ext_last = pwm_clk_i;

		// watchdog start and toggle tracking
		if (mode_now == MODE_SLEEP) begin
			nxt.wd_on = 1'b0;
		end else if (pin_rise) begin
			nxt.wd_on = 1'b1;
		end
		if (apb_wr) begin
			nxt.wd_last = tog;
		end

		// fail-safe entry: supply loss or watchdog expiry
		if (st.regs.global_control_reg[GCR_VDD_ARM] && vdd_lost_i) begin
			nxt.fs_latch = 1'b1;
		end
		if (mode_now == MODE_NORMAL && st.wd_on && !wd_alive && !st.regs.global_control_reg[GCR_WD_OFF]) begin
			nxt.fs_latch = 1'b1;
		end

		// fail-safe exit: toggle-one word, then a word in time
		if (fs_term && apb_wr) begin
			if (!st.exit_armed) begin
				nxt.exit_armed = tog;
			end else if (wd_alive && !vdd_lost_i) begin
				nxt.fs_latch = 1'b0;
				nxt.exit_armed = 1'b0;
			end else begin
				nxt.exit_armed = 1'b0;
			end
		end
		if (fs_term && st.exit_armed && !wd_alive) begin
			nxt.exit_armed = 1'b0; // window missed
		end
		if (mode_now == MODE_SLEEP) begin
			nxt.fs_latch = 1'b0;
			nxt.exit_armed = 1'b0;
		end

		// wake to ready delay
		if (mode_now == MODE_SLEEP) begin
			nxt.ready_cnt = '0;
		end else if (st.ready_cnt != READY_LAST) begin
			nxt.ready_cnt = RW'(st.ready_cnt + 1'b1);
		end
		nxt.ready = (nxt.ready_cnt == READY_LAST);

		// register writes
		if (apb_wr && wr_ok) begin
			unique case (sel)
				4'h0: nxt.regs.global_control_reg = pwdata_i[REG_W-1:0];
				4'h1: nxt.regs.pw[0] = pwdata_i[REG_W-1:0];
				4'h2: nxt.regs.pw[1] = pwdata_i[REG_W-1:0];
				4'h3: nxt.regs.setup[0] = pwdata_i[REG_W-1:0];
				4'h4: nxt.regs.setup[1] = pwdata_i[REG_W-1:0];
				4'h5: nxt.regs.limit[0] = pwdata_i[REG_W-1:0];
				4'h6: nxt.regs.limit[1] = pwdata_i[REG_W-1:0];
				default: nxt.regs = st.regs; // status or unmapped
			endcase
		end
		// defaults while asleep, pin low or in fail-safe
		if (mode_now == MODE_SLEEP || !reset_wake_i || fs_term) begin
			nxt.regs = REGS_RST;
		end

		// read data captured in the setup phase
		if (psel_i && !penable_i && !pwrite_i) begin
			unique case (sel)
				4'h0: nxt.prdata = word(st.regs.global_control_reg);
				4'h1: nxt.prdata = word(st.regs.pw[0]);
				4'h2: nxt.prdata = word(st.regs.pw[1]);
				4'h3: nxt.prdata = word(st.regs.setup[0]);
				4'h4: nxt.prdata = word(st.regs.setup[1]);
				4'h5: nxt.prdata = word(st.regs.limit[0]);
				4'h6: nxt.prdata = word(st.regs.limit[1]);
				4'h7: nxt.prdata = {21'h000000, fault_term, failsafe_flag_i, in_on, st.ready, fs_term,
					st.mode, st.mode == MODE_NORMAL};
				default: nxt.prdata = 32'h00000000;
			endcase
		end

		// channel commands
		for (int c = 0; c < 2; c++) begin
			pw = st.regs.pw[c];
			su = st.regs.setup[c];
			on_bit = pw[PW_ON];
			dctl = su[SET_DIRECT];
			// internal prescaled tick or external clock edge
			if (su[SET_CLK_INT]) begin
				tick = (st.pre_cnt[c] == su[SET_DIV +: DIV_W]);
				nxt.pre_cnt[c] = tick ? '0 : DIV_W'(st.pre_cnt[c] + 1'b1);
			end else begin
				tick = pwm_clk_i && !st.ext_last;
				nxt.pre_cnt[c] = '0;
			end
			if (tick) begin
				nxt.pwm_cnt[c] = 8'(st.pwm_cnt[c] + 1'b1);
			end
			duty_sig = (st.pwm_cnt[c] < pw[7:0]);
			cmd = (in_i[c] && dctl) || (on_bit && duty_sig && su[SET_PWM_EN]) ||
				(on_bit && !su[SET_PWM_EN]);
			if (mode_now == MODE_SLEEP || mode_now == MODE_FAULT) begin
				nxt.hson[c] = 1'b0;
			end else if (direct) begin
				nxt.hson[c] = in_i[c];
			end else begin
				nxt.hson[c] = cmd;
			end
			// input-driven switching keeps default timing
			if (direct || (in_i[c] && dctl)) begin
				nxt.cfg[c] = '0;
			end else begin
				nxt.cfg[c] = '{slew: su[SET_SLEW +: 2], delay: su[SET_DELAY +: 2]};
			end
		end
	end

	// ---------------------------------------------------------
	// state register
	// ---------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st <= ST_RST;
		end else if (ce_i) begin
			st <= nxt;
		end
	end

	// ---------------------------------------------------------
	// outputs
	// ---------------------------------------------------------
	assign prdata_o = st.prdata;
	assign hson_o = st.hson;
	assign drive_cfg_o = st.cfg;
	assign mode_o = st.mode;
	assign normal_state_flag_o = (st.mode == MODE_NORMAL);
	assign ready_o = st.ready;
	// open drain: pulled low while in fail-safe
	assign failsafe_flag_o = 1'b0;
	assign failsafe_flag_oe_o = (st.mode == MODE_FAILSAFE);

	// ---------------------------------------------------------
	// checks
	// ---------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);

	chk_sleep_off: assert property (st.mode == MODE_SLEEP |-> hson_o == 2'b00)
		else $error("channel on in sleep");
	chk_fault_off: assert property (st.mode == MODE_FAULT |-> hson_o == 2'b00)
		else $error("channel on in fault");
	chk_sleep_entry: assert property (ce_i && !wake |=> mode_o == MODE_SLEEP)
		else $error("no sleep with wake-up low");
	chk_wake_normal: assert property (ce_i && wake && !fault_term && !fs_term |=> normal_state_flag_o)
		else $error("normal mode not flagged");
	chk_direct_follow: assert property (ce_i && direct && mode_now == MODE_FAILSAFE
		|=> hson_o == $past(in_i))
		else $error("fail-safe channel ignores input");
	chk_fs_pin: assert property (mode_o == MODE_FAILSAFE |-> failsafe_flag_oe_o && !failsafe_flag_o)
		else $error("fail-safe pin not low");
	chk_fs_write_block: assert property (apb_wr && fs_term |-> pslverr_o ##1 st.regs == REGS_RST)
		else $error("write accepted in fail-safe");
	chk_wd_off_hold: assert property (ce_i && st.regs.global_control_reg[GCR_WD_OFF] && !vdd_lost_i && !fs_term
		|=> !fs_term)
		else $error("fail-safe entered with watchdog off");
	chk_default_cfg: assert property (ce_i && direct |=> drive_cfg_o == '0)
		else $error("direct mode timing not default");
	chk_pwm_gate_off: assert property (ce_i && !direct && mode_now == MODE_NORMAL && st.regs.pw[0][PW_ON]
		&& !st.regs.setup[0][SET_PWM_EN] |=> hson_o[0])
		else $error("on bit without gating ignored");
	chk_not_ready: assert property (mode_o == MODE_SLEEP |=> !ready_o)
		else $error("ready set while asleep");

	cov_normal: cover property (mode_o == MODE_SLEEP ##1 mode_o == MODE_NORMAL);
	cov_failsafe: cover property (mode_o == MODE_NORMAL ##1 mode_o == MODE_FAILSAFE);
	cov_fs_exit: cover property (mode_o == MODE_FAILSAFE ##1 mode_o == MODE_NORMAL);
	cov_fault: cover property (mode_o == MODE_FAULT);

endmodule

// ==== shared/hs_ctrl_pkg.sv ====
// How it works
// - one of four modes from three terms
// - wake-up is pin or either activity flag
// - fail-safe: armed supply loss or watchdog expiry
// - fault ORs channel, undervoltage, gated overvoltage flags
// - sleep holds both channels off
// - fault mode holds both channels off
// - pin low or fail-safe: inputs drive channels
// - watchdog runs only under its five conditions, or in the fail-safe exit window
// - input idle past timeout clears activity flag
// - both flags clear, pin low: sleep
// - pin or input rising edge wakes device
// - wake resets registers, ready after delay
// - on-command from input, on, duty, gating
// - duty comes from pulse-width low byte
// - direct control uses default delay and slew
// - internal clock drives per-channel pulse width
// - external clock pin sets pulse frequency
// - watchdog-off bit four blocks watchdog-expiry fail-safe entry
// - per-channel width, setup, current-limit registers
// - normal flag reads one in normal mode
// - fail-safe exit needs toggle-one then word
// - fail-safe: flag pin low, regs reset, blocked
package hs_ctrl_pkg;

	// ---------------------------------------------------------
	// timing
	// ---------------------------------------------------------
	localparam int CLK_MHZ = 200; // clock rate
	localparam int IN_TIMEOUT_MS = 250; // input idle timeout
	localparam int WD_TIMEOUT_MS = 310; // watchdog timeout
	localparam int READY_US = 50; // wake to functions ready
	localparam int IN_TIMEOUT_CYC = IN_TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int WD_TIMEOUT_CYC = WD_TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int READY_CYC = READY_US * CLK_MHZ;

	// ---------------------------------------------------------
	// register map, byte offsets
	// ---------------------------------------------------------
	localparam logic [7:0] OFS_GCR = 8'h00;
	localparam logic [7:0] OFS_PW0 = 8'h04;
	localparam logic [7:0] OFS_PW1 = 8'h08;
	localparam logic [7:0] OFS_SETUP0 = 8'h0C;
	localparam logic [7:0] OFS_SETUP1 = 8'h10;
	localparam logic [7:0] OFS_LIMIT0 = 8'h14;
	localparam logic [7:0] OFS_LIMIT1 = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;

	// ---------------------------------------------------------
	// fields
	// ---------------------------------------------------------
	localparam int REG_W = 15; // stored bits; bit 15 is the toggle
	localparam int TOGGLE_BIT = 15; // watchdog_toggle_bit in every write
	localparam int GCR_WD_OFF = 4; // watchdog_off_bit
	localparam int GCR_VDD_ARM = 3; // logic-supply-loss detection armed
	localparam int GCR_OV_GATE = 2; // supply_high_gate_bit
	localparam int PW_ON = 8; // channel on bit, duty in [7:0]
	localparam int SET_PWM_EN = 0; // pulse gating
	localparam int SET_CLK_INT = 1; // 1 internal, 0 external clock
	localparam int SET_DIRECT = 2; // direct input allowed
	localparam int SET_SLEW = 3; // two bits
	localparam int SET_DELAY = 5; // two bits
	localparam int SET_DIV = 7; // clock_divider_setting, three bits
	localparam int DIV_W = 3;

	// ---------------------------------------------------------
	// reset values
	// ---------------------------------------------------------
	localparam logic [REG_W-1:0] GCR_RST = 15'h0004;
	localparam logic [REG_W-1:0] SETUP_RST = 15'h0004;

	// ---------------------------------------------------------
	// types
	// ---------------------------------------------------------
	typedef enum logic [3:0] {
		MODE_SLEEP = 4'h1,
		MODE_NORMAL = 4'h2,
		MODE_FAILSAFE = 4'h4,
		MODE_FAULT = 4'h8
	} op_mode_t;

	typedef struct packed {
		logic [1:0] oc; // overcurrent_fault per channel
		logic [1:0] ot; // overtemperature_fault per channel
		logic [1:0] sc; // severe_short_fault per channel
		logic uv; // undervoltage_fault
		logic ov; // supply_high_fault
	} fault_in_t;

	typedef struct packed {
		logic [1:0] slew;
		logic [1:0] delay;
	} drive_cfg_t;

	typedef struct packed {
		logic [REG_W-1:0] global_control_reg; // global_control_reg
		logic [1:0][REG_W-1:0] pw; // pulse_width_reg
		logic [1:0][REG_W-1:0] setup; // channel_setup_reg
		logic [1:0][REG_W-1:0] limit; // current_limit_reg
	} regs_t;

	localparam regs_t REGS_RST = '{global_control_reg: GCR_RST, setup: {SETUP_RST, SETUP_RST}, default: '0};

endpackage

// ==== rtl/activity_timer.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------
// restartable timeout counter
// ---------------------------------------------------------
module activity_timer
	import hs_ctrl_pkg::*;
#(
	parameter int unsigned LIMIT = IN_TIMEOUT_CYC, // cycles to expiry
	parameter bit START_ALIVE = 1'b0 // state after reset
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	input wire logic restart_i,
	input wire logic run_i,
	output logic alive_o
);
	localparam int W = $clog2(LIMIT + 1);
	localparam logic [W-1:0] LAST = W'(LIMIT);

	typedef struct packed {
		logic [W-1:0] cnt; // cycles since last restart
	} tmr_state_t;

	tmr_state_t st; // registered state
	tmr_state_t nxt; // next state

	// count up, stick at the limit
	always_comb begin
		nxt = st;
		if (restart_i) begin
			nxt.cnt = '0;
		end else if (run_i && st.cnt != LAST) begin
			nxt.cnt = W'(st.cnt + 1'b1);
		end
	end

	// clock enable freezes the count
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			st <= START_ALIVE ? '0 : LAST;
		end else if (ce_i) begin
			st <= nxt;
		end
	end

	// alive until the limit is reached
	assign alive_o = (st.cnt != LAST);

endmodule

// ==== tb/host_model.sv ====
`timescale 1ns/1ps
// --------------------
// host side: apb master that keeps the watchdog toggle moving
// --------------------
module host_model
	import hs_ctrl_pkg::*;
(
	input wire logic clk_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	input wire logic [31:0] prdata_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o
);
	logic tog = 1'b0; // toggle bit of the next write, bench may preset it
	// idle bus at time zero
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h0;
	end
	// one transfer; an edge always passes first so strobes never double-assign
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [14:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= wr;
		paddr_o <= a;
		pwdata_o <= {16'h0000, tog, d};
		if (wr) tog = ~tog;
		@(posedge clk_i);
		penable_o <= 1'b1;
		// wait for the answer; only the bench watchdog ends a hang
		do begin
			@(posedge clk_i);
		end while (pready_i !== 1'b1);
		rd = prdata_i;
		err = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		paddr_o <= ~a; // released bus must not show a stale value
		pwdata_o <= ~pwdata_o;
	endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	import hs_ctrl_pkg::*;
	localparam int IN_TO = 40; // shortened counts
	localparam int WD_TO = 60;
	localparam int RDY = 8;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic reset_wake = 1'b0;
	logic [1:0] din = 2'b00;
	logic pwm_clk = 1'b0;
	logic vdd_lost = 1'b0;
	logic ce = 1'b1; // clock enable, dropped once to freeze the block
	fault_in_t faults = '0;
	logic fs_o, fs_oe, nflag, ready;
	logic [1:0] hson;
	drive_cfg_t [1:0] cfg;
	op_mode_t mode;
	wire logic fs_pin = fs_oe ? fs_o : 1'b1; // pulled-up open drain
	int err_total = 0;
	int cmp_count = 0;
	// --------------------
	// clock, external pwm clock, parts
	// --------------------
	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) pwm_clk <= ~pwm_clk; // rising edge every 2 cycles
	switch_mode_ctrl #(.IN_TIMEOUT(IN_TO), .WD_TIMEOUT(WD_TO), .READY_CYCLES(RDY)) i_dut (
		.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .reset_wake_i(reset_wake), .in_i(din),
		.pwm_clk_i(pwm_clk), .vdd_lost_i(vdd_lost), .faults_i(faults), .failsafe_flag_i(fs_pin),
		.failsafe_flag_o(fs_o), .failsafe_flag_oe_o(fs_oe), .hson_o(hson), .drive_cfg_o(cfg),
		.mode_o(mode), .normal_state_flag_o(nflag), .ready_o(ready));
	host_model i_host (.clk_i(clk_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata),
		.psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));
	// --------------------
	// helpers
	// --------------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [14:0] d);
		i_host.xfer(1'b1, a, d, rd, er);
	endtask
	task automatic rdr(input logic [7:0] a);
		i_host.xfer(1'b0, a, 15'h0, rd, er);
	endtask
	// sample after the edge's updates have landed
	task automatic look(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wait_mode(input op_mode_t m, input int lim, input string nm);
		int k;
		k = 0;
		while (mode !== m && k < lim) begin
			look(1);
			k++;
		end
		chk(nm, 32'(mode), 32'(m));
	endtask
	task automatic summarize;
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// --------------------
	// scenarios
	// --------------------
	task automatic t_reset;
		look(1);
		chk("mode", 32'(mode), 32'(MODE_SLEEP));
		chk("hson", 32'(hson), 32'h0);
		rdr(OFS_STATUS);
		chk("status", rd, 32'h0000_0202);
	endtask
	task automatic t_wake;
		@(posedge clk_i);
		reset_wake <= 1'b1;
		look(1);
		chk("mode", 32'(mode), 32'(MODE_NORMAL));
		chk("nflag", 32'(nflag), 32'h1);
		wr(OFS_PW0, 15'h0100);
		chk("early_err", 32'(er), 32'h1);
		repeat (RDY + 4) if (ready !== 1'b1) look(1);
		chk("ready", 32'(ready), 32'h1);
		rdr(OFS_GCR);
		chk("gcr", rd, 32'h4);
		rdr(OFS_SETUP1);
		chk("setup1", rd, 32'h4);
		rdr(OFS_PW0);
		chk("pw0", rd, 32'h0);
		rdr(8'h20);
		chk("unmapped_err", 32'(er), 32'h1);
		chk("unmapped_data", rd, 32'h0);
		wr(OFS_STATUS, 15'h7FFF);
		chk("status_wr_err", 32'(er), 32'h1);
	endtask
	task automatic t_hson;
		wr(OFS_SETUP0, 15'h005A); // internal clock, slew 3, delay 2, no input path
		wr(OFS_PW0, 15'h0100);
		look(2);
		chk("hson_on", 32'(hson[0]), 32'h1);
		chk("cfg_int", 32'(cfg[0]), 32'hE);
		wr(OFS_SETUP1, 15'h0003); // gated, zero duty never drives
		wr(OFS_PW1, 15'h0100);
		wr(OFS_PW0, 15'h0000);
		wr(OFS_SETUP0, 15'h0004);
		@(posedge clk_i);
		din <= 2'b01;
		look(2);
		chk("hson_dir", 32'(hson), 32'h1);
		chk("cfg_dir", 32'(cfg[0]), 32'h0);
		@(posedge clk_i);
		din <= 2'b00;
	endtask
	task automatic t_faults;
		int hi;
		wr(OFS_GCR, 15'h0014);
		wr(OFS_PW0, 15'h0100);
		look(3 * WD_TO); // pin kept high while inputs idle
		chk("wd_off", 32'(mode), 32'(MODE_NORMAL));
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i);
			faults <= fault_in_t'(8'h01 << i);
			look(1);
			chk("fault_mode", 32'(mode), 32'(MODE_FAULT));
			look(1);
			chk("fault_off", 32'(hson), 32'h0);
			@(posedge clk_i);
			faults <= '0;
			look(1);
			chk("fault_gone", 32'(mode), 32'(MODE_NORMAL));
		end
		// frozen block must ignore a fault that comes and goes
		@(posedge clk_i);
		ce <= 1'b0;
		faults <= fault_in_t'(8'h02);
		look(3);
		chk("ce_mode", 32'(mode), 32'(MODE_NORMAL));
		chk("ce_hson", 32'(hson), 32'h1);
		@(posedge clk_i);
		ce <= 1'b1;
		faults <= '0;
		wr(OFS_GCR, 15'h0010);
		@(posedge clk_i);
		faults <= fault_in_t'(8'h01);
		look(2);
		chk("ov_gated", 32'(mode), 32'(MODE_NORMAL));
		@(posedge clk_i);
		faults <= '0;
		wr(OFS_SETUP0, 15'h0001); // gated, external clock
		wr(OFS_PW0, 15'h0180);
		hi = 0;
		repeat (600) begin
			look(1);
			if (hson[0] === 1'b1) hi++;
		end
		chk("ext_duty", 32'(hi > 200 && hi < 400), 32'h1);
	endtask
	task automatic t_wdog;
		wr(OFS_GCR, 15'h0004);
		wr(OFS_PW0, 15'h0000);
		look(WD_TO - 6);
		chk("wd_run", 32'(mode), 32'(MODE_NORMAL));
		@(posedge clk_i);
		din <= 2'b10;
		wait_mode(MODE_FAILSAFE, 12, "wd_expiry");
		look(2);
		chk("fs_hson", 32'(hson), 32'h2);
		chk("fs_pin", 32'(fs_pin), 32'h0);
		rdr(OFS_SETUP0);
		chk("fs_regs", rd, 32'h4);
		i_host.tog = 1'b0;
		wr(OFS_PW0, 15'h0100);
		chk("fs_wr_err", 32'(er), 32'h1);
		i_host.tog = 1'b1;
		wr(OFS_PW1, 15'h0000); // arm the exit
		wr(OFS_PW1, 15'h0000);
		look(1);
		chk("fs_exit", 32'(mode), 32'(MODE_NORMAL));
		wr(OFS_GCR, 15'h000C);
		@(posedge clk_i);
		vdd_lost <= 1'b1;
		wait_mode(MODE_FAILSAFE, 4, "vdd_loss");
		@(posedge clk_i);
		vdd_lost <= 1'b0;
	endtask
	task automatic t_sleep;
		@(posedge clk_i);
		reset_wake <= 1'b0;
		din <= 2'b00;
		look(IN_TO - 4);
		chk("still_awake", 32'(mode !== MODE_SLEEP), 32'h1);
		wait_mode(MODE_SLEEP, 12, "sleep");
		chk("sleep_off", 32'(hson), 32'h0);
		@(posedge clk_i);
		din <= 2'b01;
		// activity flag rises one edge after the input, the mode one edge later
		look(2);
		chk("in_wake", 32'(mode), 32'(MODE_NORMAL));
		look(1);
		chk("pin_low_hson", 32'(hson), 32'h1);
	endtask
	// --------------------
	// main sequence and hang guard
	// --------------------
	initial begin
		repeat (10) @(posedge clk_i);
		srst_i <= 1'b0;
		t_reset();
		t_wake();
		t_hson();
		t_faults();
		t_wdog();
		t_sleep();
		summarize();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		summarize();
	end
endmodule
